/* core/btr_pkg.sv */
// Shared constants for the bus timing and refresh register slice
package btr_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned TCNT_W = 8;
    localparam int unsigned RCNT_W = 10;
    localparam int unsigned PRE_W = 12;

    localparam logic [15:0] ADDR_STROBE_TIMING = 16'h0000;
    localparam logic [15:0] ADDR_REFRESH_CSR = 16'h0004;
    localparam logic [15:0] ADDR_TIMER_COUNTER = 16'h0008;
    localparam logic [15:0] ADDR_TIME_CONSTANT = 16'h000C;
    localparam logic [15:0] ADDR_REFRESH_COUNT = 16'h0010;
    localparam logic [15:0] ADDR_MEM_CTRL = 16'h0014;
    localparam logic [3:0] MODE_AREA2_PAGE = 4'h2;
    localparam logic [3:0] MODE_AREA3_PAGE = 4'h3;

    localparam logic [7:0] WRITE_KEY = 8'hA5;
    localparam logic [5:0] COUNT_WRITE_KEY = 6'h29;

    localparam int unsigned A5_ASSERT_LSB = 6;
    localparam int unsigned A6_ASSERT_LSB = 4;
    localparam int unsigned A5_NEGATE_LSB = 2;
    localparam int unsigned A6_NEGATE_LSB = 0;

    localparam int unsigned CMF_BIT = 7;
    localparam int unsigned COMPARE_MATCH_IRQ_ENABLE_BIT = 6;
    localparam int unsigned CKS_LSB = 3;
    localparam int unsigned OVF_BIT = 2;
    localparam int unsigned OVERFLOW_IRQ_ENABLE_BIT = 1;
    localparam int unsigned COUNT_LIMIT_SELECT_BIT = 0;

    localparam int unsigned REFRESH_ENABLE_BIT = 0;
    localparam int unsigned REFRESH_MODE_SELECT_BIT = 1;
    localparam int unsigned A5_WAIT_LSB = 4;
    localparam int unsigned A6_WAIT_LSB = 8;
    localparam int unsigned MODE2_DONE_BIT = 12;
    localparam int unsigned MODE3_DONE_BIT = 13;

    localparam logic [7:0] STROBE_RESET = 8'h00;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [10:0] LIMIT_LONG = 11'h400;
    localparam logic [10:0] LIMIT_SHORT = 11'h200;

    localparam logic [11:0] PRE_MASK_4 = 12'h003;
    localparam logic [11:0] PRE_MASK_16 = 12'h00F;
    localparam logic [11:0] PRE_MASK_64 = 12'h03F;
    localparam logic [11:0] PRE_MASK_256 = 12'h0FF;
    localparam logic [11:0] PRE_MASK_1024 = 12'h3FF;
    localparam logic [11:0] PRE_MASK_2048 = 12'h7FF;
    localparam logic [11:0] PRE_MASK_4096 = 12'hFFF;
endpackage

/* core/btr_prescaler.sv */
// Bus clock prescaler that paces the refresh timer counter
`timescale 1ns/1ps
module btr_prescaler #(
    parameter int unsigned W = btr_pkg::PRE_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_sel,
    output logic o_tick
);
    import btr_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } btr_pre_state_t;

    btr_pre_state_t st;
    btr_pre_state_t next_st;

    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        unique case (sel)
            3'h1: div_mask = PRE_MASK_4;
            3'h2: div_mask = PRE_MASK_16;
            3'h3: div_mask = PRE_MASK_64;
            3'h4: div_mask = PRE_MASK_256;
            3'h5: div_mask = PRE_MASK_1024;
            3'h6: div_mask = PRE_MASK_2048;
            3'h7: div_mask = PRE_MASK_4096;
            default: div_mask = 12'h000;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (i_sel == 3'h0) begin
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
            next_st.tick = (st.cnt[11:0] & div_mask(i_sel)) == div_mask(i_sel);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule

/* core/btr_regs.sv */
// Strobe timing, SDRAM mode load and refresh timer register slice
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module btr_regs (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic [btr_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [btr_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_WR_WORD,
    input wire logic I_RD,
    input wire logic I_REFRESH_DONE,
    output logic [btr_pkg::DATA_W-1:0] O_RDATA,
    output logic O_MODE_WR,
    output logic O_MODE_AREA3,
    output logic [9:0] O_MODE_ADDR,
    output logic O_REFRESH_REQ,
    output logic O_CMI_REQ,
    output logic O_OVI_REQ,
    output logic [2:0] O_AREA5_ASSERT_HALF,
    output logic [2:0] O_AREA5_NEGATE_HALF,
    output logic [3:0] O_AREA5_WIDTH,
    output logic [2:0] O_AREA6_ASSERT_HALF,
    output logic [2:0] O_AREA6_NEGATE_HALF,
    output logic [3:0] O_AREA6_WIDTH
);
    import btr_pkg::*;

    typedef struct packed {
        logic [7:0] strobe;
        logic compare_match_flag;
        logic compare_match_irq_enable;
        logic [2:0] cks;
        logic ovf;
        logic overflow_irq_enable;
        logic count_limit_select;
        logic cmf_clr_arm;
        logic [TCNT_W-1:0] tcnt;
        logic [TCNT_W-1:0] tconst;
        logic [RCNT_W-1:0] rcount;
        logic refresh_enable;
        logic refresh_mode_select;
        logic [2:0] a5_wait;
        logic [2:0] a6_wait;
        logic [1:0] mode_done;
        logic [DATA_W-1:0] rdata;
        logic mode_wr;
        logic mode_area3;
        logic [9:0] mode_addr;
        logic refresh_req;
    } btr_state_t;

    btr_state_t st;
    btr_state_t next_st;
    logic tick;
    logic [1:0] assert_code [2];
    logic [1:0] negate_code [2];
    logic [2:0] wait_code [2];
    logic [2:0] assert_half [2];
    logic [2:0] negate_half [2];
    logic [3:0] width [2];

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        hit = (addr == off);
    endfunction

    // Keyed registers take only word writes with the key byte on top
    function automatic logic keyed(input logic word, input logic [15:0] data);
        keyed = word && (data[15:8] == WRITE_KEY);
    endfunction

    function automatic logic [7:0] csr_image(input btr_state_t s);
        csr_image = {s.compare_match_flag, s.compare_match_irq_enable, s.cks, s.ovf, s.overflow_irq_enable, s.count_limit_select};
    endfunction

    btr_prescaler #(
        .W(PRE_W)
    ) u_prescaler (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_sel(st.cks),
        .o_tick(tick)
    );

    assign assert_code[0] = st.strobe[A5_ASSERT_LSB +: 2];
    assign assert_code[1] = st.strobe[A6_ASSERT_LSB +: 2];
    assign negate_code[0] = st.strobe[A5_NEGATE_LSB +: 2];
    assign negate_code[1] = st.strobe[A6_NEGATE_LSB +: 2];
    assign wait_code[0] = st.a5_wait;
    assign wait_code[1] = st.a6_wait;

    // One decoder per area so the two cards never share timing
    for (genvar g = 0; g < 2; g++) begin : g_area
        btr_strobe_timing u_timing (
            .i_clk(I_SYS_CLK),
            .i_rst(I_SYS_RST),
            .i_assert_code(assert_code[g]),
            .i_negate_code(negate_code[g]),
            .i_wait(wait_code[g]),
            .o_assert_half(assert_half[g]),
            .o_negate_half(negate_half[g]),
            .o_width(width[g])
        );
    end

    always_comb begin
        logic match;
        logic ovf_set;
        logic cbr;
        logic [10:0] sum;
        logic [10:0] limit;
        match = 1'b0;
        ovf_set = 1'b0;
        cbr = st.refresh_enable && !st.refresh_mode_select;
        sum = {1'b0, st.rcount} + 11'h001;
        limit = st.count_limit_select ? LIMIT_SHORT : LIMIT_LONG;
        next_st = st;
        next_st.mode_wr = 1'b0;
        next_st.refresh_req = 1'b0;
        next_st.rdata = 16'h0000;

        // Compare happens only on a prescaler tick, so a stopped clock
        // select also freezes matching.
        if (tick) begin
            if (st.tcnt == st.tconst) begin
                next_st.tcnt = '0;
                match = 1'b1;
            end else begin
                next_st.tcnt = st.tcnt + 1'b1;
            end
        end
        if (match) begin
            if (sum >= limit) begin
                next_st.rcount = '0;
                ovf_set = 1'b1;
            end else begin
                next_st.rcount = sum[RCNT_W-1:0];
            end
        end

        if (I_WR) begin
            if (hit(I_ADDR, ADDR_STROBE_TIMING)) begin
                next_st.strobe = I_WDATA[7:0];
            end
            if (hit(I_ADDR, ADDR_REFRESH_CSR) && keyed(I_WR_WORD, I_WDATA)) begin
                if (!I_WDATA[CMF_BIT]) begin
                    next_st.cmf_clr_arm = 1'b1;
                end
                if (!I_WDATA[OVF_BIT]) begin
                    next_st.ovf = 1'b0;
                end
                next_st.compare_match_irq_enable = I_WDATA[COMPARE_MATCH_IRQ_ENABLE_BIT];
                next_st.cks = I_WDATA[CKS_LSB +: 3];
                next_st.overflow_irq_enable = I_WDATA[OVERFLOW_IRQ_ENABLE_BIT];
                next_st.count_limit_select = I_WDATA[COUNT_LIMIT_SELECT_BIT];
            end
            if (hit(I_ADDR, ADDR_TIMER_COUNTER) && keyed(I_WR_WORD, I_WDATA)) begin
                next_st.tcnt = I_WDATA[7:0];
            end
            if (hit(I_ADDR, ADDR_TIME_CONSTANT) && keyed(I_WR_WORD, I_WDATA)) begin
                next_st.tconst = I_WDATA[7:0];
            end
            if (hit(I_ADDR, ADDR_REFRESH_COUNT) && I_WR_WORD
                    && I_WDATA[15:10] == COUNT_WRITE_KEY) begin
                next_st.rcount = I_WDATA[RCNT_W-1:0];
            end
            if (hit(I_ADDR, ADDR_MEM_CTRL)) begin
                next_st.refresh_enable = I_WDATA[REFRESH_ENABLE_BIT];
                next_st.refresh_mode_select = I_WDATA[REFRESH_MODE_SELECT_BIT];
                next_st.a5_wait = I_WDATA[A5_WAIT_LSB +: 3];
                next_st.a6_wait = I_WDATA[A6_WAIT_LSB +: 3];
            end
            // Mode load: the offset inside the page is the value, data is
            // dropped; misaligned offsets are ignored.
            if ((I_ADDR[15:12] == MODE_AREA2_PAGE || I_ADDR[15:12] == MODE_AREA3_PAGE)
                    && I_ADDR[1:0] == 2'h0) begin
                next_st.mode_wr = 1'b1;
                next_st.mode_area3 = (I_ADDR[15:12] == MODE_AREA3_PAGE);
                next_st.mode_addr = I_ADDR[11:2];
                if (I_ADDR[15:12] == MODE_AREA3_PAGE) begin
                    next_st.mode_done[1] = 1'b1;
                end else begin
                    next_st.mode_done[0] = 1'b1;
                end
            end
        end

        // The clear only completes on a real CBR refresh after the armed write
        if (I_REFRESH_DONE && st.cmf_clr_arm && cbr) begin
            next_st.compare_match_flag = 1'b0;
            next_st.cmf_clr_arm = 1'b0;
        end

        // Sets come last so an event in a clearing cycle is kept
        if (match) begin
            next_st.compare_match_flag = 1'b1;
            next_st.refresh_req = cbr;
        end
        if (ovf_set) begin
            next_st.ovf = 1'b1;
        end

        if (I_RD) begin
            if (hit(I_ADDR, ADDR_STROBE_TIMING)) begin
                next_st.rdata = {8'h00, st.strobe};
            end else if (hit(I_ADDR, ADDR_REFRESH_CSR)) begin
                next_st.rdata = {8'h00, csr_image(st)};
            end else if (hit(I_ADDR, ADDR_TIMER_COUNTER)) begin
                next_st.rdata = {8'h00, st.tcnt};
            end else if (hit(I_ADDR, ADDR_TIME_CONSTANT)) begin
                next_st.rdata = {8'h00, st.tconst};
            end else if (hit(I_ADDR, ADDR_REFRESH_COUNT)) begin
                next_st.rdata = {6'h00, st.rcount};
            end else if (hit(I_ADDR, ADDR_MEM_CTRL)) begin
                next_st.rdata = {2'h0, st.mode_done, 1'b0, st.a6_wait,
                                 1'b0, st.a5_wait, 2'h0, st.refresh_mode_select, st.refresh_enable};
            end
        end
    end

    // Only power-on reset reaches this slice; manual reset and standby
    // have no path in, so every field keeps its value through them.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            st <= '0;
            st.strobe <= STROBE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign O_RDATA = st.rdata;
    assign O_MODE_WR = st.mode_wr;
    assign O_MODE_AREA3 = st.mode_area3;
    assign O_MODE_ADDR = st.mode_addr;
    assign O_REFRESH_REQ = st.refresh_req;
    // Requests follow the flags; software should leave the compare enable
    // off while CBR or auto-refresh runs.
    assign O_CMI_REQ = st.compare_match_flag && st.compare_match_irq_enable;
    assign O_OVI_REQ = st.ovf && st.overflow_irq_enable;
    assign O_AREA5_ASSERT_HALF = assert_half[0];
    assign O_AREA5_NEGATE_HALF = negate_half[0];
    assign O_AREA5_WIDTH = width[0];
    assign O_AREA6_ASSERT_HALF = assert_half[1];
    assign O_AREA6_NEGATE_HALF = negate_half[1];
    assign O_AREA6_WIDTH = width[1];
endmodule

/* core/btr_strobe_timing.sv */
// Per-area strobe timing decode for the card interface
`timescale 1ns/1ps
module btr_strobe_timing (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_assert_code,
    input wire logic [1:0] i_negate_code,
    input wire logic [2:0] i_wait,
    output logic [2:0] o_assert_half,
    output logic [2:0] o_negate_half,
    output logic [3:0] o_width
);
    import btr_pkg::*;

    typedef struct packed {
        logic [2:0] assert_half;
        logic [2:0] negate_half;
        logic [3:0] width;
    } btr_stb_state_t;

    btr_stb_state_t st;
    btr_stb_state_t next_st;

    // Delay in half cycles: code 0..3 gives 1,3,5,7 halves
    function automatic logic [2:0] halves(input logic [1:0] code);
        halves = {code, 1'b1};
    endfunction

    always_comb begin
        next_st.assert_half = halves(i_assert_code);
        next_st.negate_half = halves(i_negate_code);
        next_st.width = {1'b0, i_wait} + 4'h1;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_assert_half = st.assert_half;
    assign o_negate_half = st.negate_half;
    assign o_width = st.width;
endmodule

/* verif/btr_mem_model.sv */
// Behavioural memory side: answers refresh starts, notes mode loads
`timescale 1ns/1ps
module btr_mem_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_delay,
    input wire logic i_refresh_req,
    input wire logic i_mode_wr,
    output logic o_refresh_done,
    output logic o_mode_seen
);
    logic [3:0] cnt;
    initial o_refresh_done = 1'b0;
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt <= 4'h0;
            o_refresh_done <= 1'b0;
            o_mode_seen <= 1'b0;
        end else begin
            // A late answer lets the flag clear land well after the match
            cnt <= i_refresh_req ? i_delay : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
            o_refresh_done <= cnt == 4'h1;
            if (i_mode_wr) o_mode_seen <= 1'b1;
        end
    end
endmodule

/* verif/btr_regs_checker.sv */
// Port assertions for the timing and refresh register slice
`timescale 1ns/1ps
module btr_regs_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic [btr_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [btr_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [btr_pkg::DATA_W-1:0] O_RDATA,
    input wire logic O_MODE_WR,
    input wire logic O_MODE_AREA3,
    input wire logic [9:0] O_MODE_ADDR,
    input wire logic O_REFRESH_REQ,
    input wire logic O_CMI_REQ,
    input wire logic O_OVI_REQ,
    input wire logic [2:0] O_AREA5_ASSERT_HALF,
    input wire logic [2:0] O_AREA5_NEGATE_HALF,
    input wire logic [3:0] O_AREA5_WIDTH,
    input wire logic [2:0] O_AREA6_ASSERT_HALF,
    input wire logic [2:0] O_AREA6_NEGATE_HALF,
    input wire logic [3:0] O_AREA6_WIDTH
);
    import btr_pkg::*;
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    sequence s_mode_wr;
        I_WR && I_ADDR[15:13] == 3'h1 && I_ADDR[1:0] == 2'h0;
    endsequence
    property p_mode_load;
        s_mode_wr |=> O_MODE_WR && O_MODE_ADDR == $past(I_ADDR[11:2])
            && O_MODE_AREA3 == $past(I_ADDR[12]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("bad mode load");
    property p_mode_quiet;
        !$past(I_WR && I_ADDR[15:13] == 3'h1 && I_ADDR[1:0] == 2'h0) |-> !O_MODE_WR;
    endproperty
    a_mode_quiet: assert property (p_mode_quiet) else $error("stray mode load");
    property p_rdata_idle;
        !$past(I_RD) |-> O_RDATA == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_cmi;
        $past(I_RD && I_ADDR == ADDR_REFRESH_CSR)
            |-> $past(O_CMI_REQ) == (O_RDATA[CMF_BIT] && O_RDATA[COMPARE_MATCH_IRQ_ENABLE_BIT]);
    endproperty
    a_cmi: assert property (p_cmi) else $error("compare request mismatch");
    property p_ovi;
        $past(I_RD && I_ADDR == ADDR_REFRESH_CSR)
            |-> $past(O_OVI_REQ) == (O_RDATA[OVF_BIT] && O_RDATA[OVERFLOW_IRQ_ENABLE_BIT]);
    endproperty
    a_ovi: assert property (p_ovi) else $error("overflow request mismatch");
    property p_refresh_pulse;
        $rose(O_REFRESH_REQ) |=> !O_REFRESH_REQ [*3];
    endproperty
    a_refresh_pulse: assert property (p_refresh_pulse) else $error("refresh too close");
    property p_strobe5;
        I_WR && I_ADDR == ADDR_STROBE_TIMING |-> ##2
            O_AREA5_ASSERT_HALF == {$past(I_WDATA[7:6], 2), 1'b1}
            && O_AREA5_NEGATE_HALF == {$past(I_WDATA[3:2], 2), 1'b1};
    endproperty
    a_strobe5: assert property (p_strobe5) else $error("area 5 timing");
    property p_strobe6;
        I_WR && I_ADDR == ADDR_STROBE_TIMING |-> ##2
            O_AREA6_ASSERT_HALF == {$past(I_WDATA[5:4], 2), 1'b1}
            && O_AREA6_NEGATE_HALF == {$past(I_WDATA[1:0], 2), 1'b1};
    endproperty
    a_strobe6: assert property (p_strobe6) else $error("area 6 timing");
    property p_width;
        I_WR && I_ADDR == ADDR_MEM_CTRL |-> ##2
            O_AREA5_WIDTH == {1'b0, $past(I_WDATA[6:4], 2)} + 4'h1
            && O_AREA6_WIDTH == {1'b0, $past(I_WDATA[10:8], 2)} + 4'h1;
    endproperty
    a_width: assert property (p_width) else $error("strobe width");
    c_mode: cover property (O_MODE_WR);
    c_refresh: cover property (O_REFRESH_REQ);
    c_ovi: cover property (O_OVI_REQ);
endmodule

/* verif/tb_btr_regs.sv */
// Self-checking bench for the timing and refresh register slice
`timescale 1ns/1ps
module tb_btr_regs;
    import btr_pkg::*;
    logic I_SYS_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic [15:0] I_ADDR = 16'h0000;
    logic [15:0] I_WDATA = 16'h0000;
    logic I_WR = 1'b0, I_WR_WORD = 1'b1, I_RD = 1'b0, I_REFRESH_DONE;
    logic [15:0] O_RDATA;
    logic O_MODE_WR, O_MODE_AREA3, O_REFRESH_REQ, O_CMI_REQ, O_OVI_REQ, seen, rd_d = 1'b0;
    logic [9:0] O_MODE_ADDR;
    logic [2:0] O_AREA5_ASSERT_HALF, O_AREA5_NEGATE_HALF, O_AREA6_ASSERT_HALF, O_AREA6_NEGATE_HALF;
    logic [3:0] O_AREA5_WIDTH, O_AREA6_WIDTH, delay;
    logic [15:0] rd_q [$];
    logic [10:0] mode_q [$];
    logic [15:0] div [8] = '{16'h0, 16'h4, 16'h10, 16'h40, 16'h100, 16'h400, 16'h800, 16'h1000};
    int fails = 0;
    int compares = 0;
    btr_regs u_dut (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_WR_WORD(I_WR_WORD), .I_RD(I_RD),
        .I_REFRESH_DONE(I_REFRESH_DONE), .O_RDATA(O_RDATA), .O_MODE_WR(O_MODE_WR),
        .O_MODE_AREA3(O_MODE_AREA3), .O_MODE_ADDR(O_MODE_ADDR), .O_REFRESH_REQ(O_REFRESH_REQ),
        .O_CMI_REQ(O_CMI_REQ), .O_OVI_REQ(O_OVI_REQ), .O_AREA5_ASSERT_HALF(O_AREA5_ASSERT_HALF),
        .O_AREA5_NEGATE_HALF(O_AREA5_NEGATE_HALF), .O_AREA5_WIDTH(O_AREA5_WIDTH),
        .O_AREA6_ASSERT_HALF(O_AREA6_ASSERT_HALF), .O_AREA6_NEGATE_HALF(O_AREA6_NEGATE_HALF),
        .O_AREA6_WIDTH(O_AREA6_WIDTH));
    btr_mem_model u_mem (.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST), .i_delay(delay),
        .i_refresh_req(O_REFRESH_REQ), .i_mode_wr(O_MODE_WR), .o_refresh_done(I_REFRESH_DONE),
        .o_mode_seen(seen));
    initial forever #5 I_SYS_CLK = ~I_SYS_CLK;
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        compares++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(posedge I_SYS_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR_WORD <= w;
        @(posedge I_SYS_CLK);
        I_WR <= 1'b0;
        I_WR_WORD <= 1'b1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] want);
        @(posedge I_SYS_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        rd_q.push_back(want);
        @(posedge I_SYS_CLK);
        I_RD <= 1'b0;
    endtask
    task automatic wait_ev(input int which, input int lim, output int n);
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge I_SYS_CLK);
            #1;
            n++;
            s = which == 0 ? O_REFRESH_REQ : which == 1 ? O_CMI_REQ
                : which == 2 ? O_OVI_REQ : I_REFRESH_DONE;
        end
        chk({15'h0000, s}, 16'h0001);
    endtask
    task automatic mem(input logic en);
        logic [2:0] w5, w6;
        w5 = 3'($urandom);
        w6 = 3'($urandom);
        wr(ADDR_MEM_CTRL, {5'h00, w6, 1'b0, w5, 3'h0, en});
        rd(16'h0018, 16'h0000);
        chk({8'h00, O_AREA5_WIDTH, O_AREA6_WIDTH}, {8'h00, {1'b0, w5} + 4'h1, {1'b0, w6} + 4'h1});
    endtask
    always @(posedge I_SYS_CLK) begin
        rd_d <= I_RD;
        if (rd_d === 1'b1) chk(O_RDATA, rd_q.pop_front());
        if (O_MODE_WR === 1'b1)
            chk({5'h00, O_MODE_AREA3, O_MODE_ADDR},
                mode_q.size() > 0 ? {5'h00, mode_q.pop_front()} : 16'hFFFF);
    end
    initial begin
        repeat (60000) @(posedge I_SYS_CLK);
        fails++;
        final_report();
    end
    initial begin
        int n;
        logic [11:0] x;
        logic [7:0] v;
        n = $urandom(74281);
        delay = 4'(1 + $urandom % 6);
        repeat (3) @(posedge I_SYS_CLK);
        I_SYS_RST <= 1'b0;
        rd(ADDR_STROBE_TIMING, 16'h0000);
        rd(ADDR_REFRESH_CSR, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            v = i < 4 ? {i[1:0], ~i[1:0], ~i[1:0], i[1:0]} : 8'($urandom);
            wr(ADDR_STROBE_TIMING, {8'h00, v});
            rd(ADDR_STROBE_TIMING, {8'h00, v});
            chk({4'h0, O_AREA5_ASSERT_HALF, O_AREA5_NEGATE_HALF, O_AREA6_ASSERT_HALF,
                O_AREA6_NEGATE_HALF}, {4'h0, v[7:6], 1'b1, v[3:2], 1'b1, v[5:4], 1'b1,
                v[1:0], 1'b1});
        end
        for (int i = 0; i < 4; i++) begin
            x = i == 0 ? 12'hFFC : i == 1 ? 12'h000 : 12'($urandom) & 12'hFFC;
            mode_q.push_back({i[0], x[11:2]});
            wr({3'h1, i[0], x}, 16'($urandom));
        end
        wr(16'h2231, 16'h0000);
        rd(16'h0018, 16'h0000);
        chk({15'h0000, seen}, 16'h0001);
        wr(ADDR_REFRESH_CSR, 16'h5A47);
        rd(ADDR_REFRESH_CSR, 16'h0000);
        wr(ADDR_REFRESH_CSR, 16'hA547, 1'b0);
        rd(ADDR_REFRESH_CSR, 16'h0000);
        wr(ADDR_REFRESH_CSR, 16'hA5C7);
        rd(ADDR_REFRESH_CSR, 16'h0043);
        wr(ADDR_TIME_CONSTANT, 16'h5A02);
        rd(ADDR_TIME_CONSTANT, 16'h0000);
        // Refresh off at first, so the armed clear cannot happen before the read
        mem(1'b0);
        wr(ADDR_TIME_CONSTANT, 16'hA502);
        wr(ADDR_REFRESH_CSR, 16'hA548);
        wait_ev(1, 100, n);
        rd(ADDR_REFRESH_CSR, 16'h00C8);
        wr(ADDR_REFRESH_CSR, 16'hA548);
        rd(ADDR_REFRESH_CSR, 16'h00C8);
        mem(1'b1);
        wait_ev(3, 100, n);
        wr(ADDR_REFRESH_CSR, 16'hA540);
        rd(ADDR_REFRESH_CSR, 16'h0040);
        chk({15'h0000, O_CMI_REQ}, 16'h0000);
        wr(ADDR_TIME_CONSTANT, 16'hA500);
        for (int s = 1; s < 8; s++) begin
            wr(ADDR_REFRESH_CSR, {8'hA5, 2'h0, s[2:0], 3'h0});
            // Divider phase after a select change is open, so two pulses are skipped
            wait_ev(0, 9000, n);
            wait_ev(0, 9000, n);
            wait_ev(0, 9000, n);
            chk(n[15:0], div[s]);
        end
        // Fastest divider first, so a broken stop or mode gate shows many pulses
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_MEM_CTRL, k == 0 ? 16'h0001 : 16'h0003);
            wr(ADDR_REFRESH_CSR, 16'hA508);
            if (k == 0) wr(ADDR_REFRESH_CSR, 16'hA500);
            // A tick already in flight may still start one refresh
            repeat (4) @(posedge I_SYS_CLK);
            n = 0;
            repeat (300) begin
                @(posedge I_SYS_CLK);
                #1;
                if (O_REFRESH_REQ !== 1'b0) n++;
            end
            chk(n[15:0], 16'h0000);
        end
        wr(ADDR_REFRESH_CSR, 16'hA500);
        mem(1'b0);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_REFRESH_COUNT, i == 0 ? 16'hA5FE : 16'hA7FE);
            wr(ADDR_REFRESH_CSR, {8'hA5, 7'h05, ~i[0]});
            wait_ev(2, 20, n);
            wr(ADDR_REFRESH_CSR, {8'hA5, 7'h02, ~i[0]});
            rd(ADDR_REFRESH_CSR, {8'h00, 7'h42, ~i[0]});
            chk({15'h0000, O_OVI_REQ}, 16'h0000);
            rd(ADDR_REFRESH_COUNT, 16'h0000);
            wr(ADDR_REFRESH_CSR, 16'hA500);
            rd(ADDR_REFRESH_CSR, 16'h0080);
        end
        wr(ADDR_STROBE_TIMING, 16'h00FF);
        wr(ADDR_REFRESH_CSR, 16'hA57B);
        @(posedge I_SYS_CLK);
        I_SYS_RST <= 1'b1;
        repeat (3) @(posedge I_SYS_CLK);
        I_SYS_RST <= 1'b0;
        rd(ADDR_STROBE_TIMING, 16'h0000);
        rd(ADDR_REFRESH_CSR, 16'h0000);
        final_report();
    end
endmodule
bind btr_regs btr_regs_checker u_chk (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_MODE_WR(O_MODE_WR), .O_MODE_AREA3(O_MODE_AREA3), .O_MODE_ADDR(O_MODE_ADDR),
    .O_REFRESH_REQ(O_REFRESH_REQ), .O_CMI_REQ(O_CMI_REQ), .O_OVI_REQ(O_OVI_REQ),
    .O_AREA5_ASSERT_HALF(O_AREA5_ASSERT_HALF), .O_AREA5_NEGATE_HALF(O_AREA5_NEGATE_HALF),
    .O_AREA5_WIDTH(O_AREA5_WIDTH), .O_AREA6_ASSERT_HALF(O_AREA6_ASSERT_HALF),
    .O_AREA6_NEGATE_HALF(O_AREA6_NEGATE_HALF), .O_AREA6_WIDTH(O_AREA6_WIDTH));
